/* hw/ssmc_top.sv */
// System sleep and monitor mode controller with AXI4-Lite registers.
//
// Function
// - Sleep trigger pin puts chip in levels 3-5.
// - Trigger falling edge wakes the chip.
// - System sleep allowed only when both paths primed.
// - Level 3 synth, 4 regulators, 5 processor.
// - Level 2: enable edges power channel down/up.
// - Monitor enable enters self-sequenced monitor mode.
// - Cycle sleep/detect until hit or disable.
// - Detection drives the wake-up output.
// - Monitor has levels, delays, durations, order flag.
// - Five detector choices offered.
// - Level above threshold for duration detects.
// - Fourteen sync correlators in deviation mode detect.
// - Buffer detect samples, replay after wake.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module ssmc_top #(
   parameter int SAMPLE_W = 16,
   parameter int DEPTH = 64
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_trigger_pin,
   input wire logic monitor_enable_pin,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic paths_primed,
   input wire logic freq_dev_mode,
   input wire logic [ssmc_pkg::SYNC_N-1:0] sync_match,
   input wire logic spectral_hit,
   input wire logic [15:0] rx_level,
   input wire logic [SAMPLE_W-1:0] rx_sample,
   input wire logic rx_sample_valid,
   output logic [2:0] power_down_level,
   output logic tx_chan_down,
   output logic rx_chan_down,
   output logic wake_pin,
   output logic [SAMPLE_W-1:0] replay_sample,
   output logic replay_valid,
   output logic irq
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
   if (SAMPLE_W < 1) $error("SAMPLE_W must be positive");

   // Bus and register state.
   logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   ssmc_pkg::ssmc_ctrl_s ctrl_reg, ctrl_next;
   logic [31:0] init_reg, init_next, det_reg, det_next, slp_reg, slp_next, ldur_reg, ldur_next;
   logic [15:0] thr_reg, thr_next;
   logic [ssmc_pkg::IRQ_N-1:0] ist_reg, ist_next, mask_reg, mask_next, ev;
   logic irq_reg, irq_next, replay_go;
   // Sequencer state.
   ssmc_pkg::ssmc_state_e state_reg, state_next;
   logic [31:0] us_reg, us_next, lcnt_reg, lcnt_next;
   logic [ssmc_pkg::PRE_W-1:0] pre_reg, pre_next;
   logic trig_q_reg, tx_q_reg, rx_q_reg, txd_reg, txd_next, rxd_reg, rxd_next;
   logic wake_reg, wake_next;
   logic [2:0] pdl_reg, pdl_next;
   logic hit, lvl_hit, sync_hit, lvl_ok, t_done;
   // Sample buffer state.
   logic [SAMPLE_W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0] fill_reg, fill_next, rcnt_reg, rcnt_next;
   logic [SAMPLE_W-1:0] rs_reg, rs_next;
   logic rv_reg, rv_next, buf_wr;

   // Byte-lane merge for partial writes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Slave handshakes and register file; address and data may arrive in either order.
   always_comb begin
      awready_next = awready_reg;
      wready_next = wready_reg;
      arready_next = arready_reg;
      bvalid_next = bvalid_reg;
      rvalid_next = rvalid_reg;
      bresp_next = bresp_reg;
      rresp_next = rresp_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      ctrl_next.replay = 1'b0;
      init_next = init_reg;
      det_next = det_reg;
      slp_next = slp_reg;
      ldur_next = ldur_reg;
      thr_next = thr_reg;
      mask_next = mask_reg;
      ist_next = ist_reg;
      if (s_axi_awvalid && awready_reg) begin
         awready_next = 1'b0;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         wready_next = 1'b0;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
         awready_next = 1'b1;
         wready_next = 1'b1;
         bvalid_next = 1'b1;
         bresp_next = ssmc_pkg::RESP_OKAY;
         unique case (awaddr_reg)
            ssmc_pkg::ADDR_CTRL: ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
            ssmc_pkg::ADDR_INIT: init_next = merge(init_reg, wdata_reg, wstrb_reg);
            ssmc_pkg::ADDR_DET: det_next = merge(det_reg, wdata_reg, wstrb_reg);
            ssmc_pkg::ADDR_SLP: slp_next = merge(slp_reg, wdata_reg, wstrb_reg);
            ssmc_pkg::ADDR_THR: thr_next = 16'(merge({16'h0, thr_reg}, wdata_reg, wstrb_reg));
            ssmc_pkg::ADDR_LDUR: ldur_next = merge(ldur_reg, wdata_reg, wstrb_reg);
            ssmc_pkg::ADDR_MASK: mask_next = wstrb_reg[0] ? wdata_reg[ssmc_pkg::IRQ_N-1:0] : mask_reg;
            ssmc_pkg::ADDR_STAT, ssmc_pkg::ADDR_IRQ: ;
            default: bresp_next = ssmc_pkg::RESP_SLVERR;
         endcase
         ctrl_next.rsvd = '0;
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rresp_next = ssmc_pkg::RESP_OKAY;
         rdata_next = 32'h0;
         unique case (s_axi_araddr)
            ssmc_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
            ssmc_pkg::ADDR_INIT: rdata_next = init_reg;
            ssmc_pkg::ADDR_DET: rdata_next = det_reg;
            ssmc_pkg::ADDR_SLP: rdata_next = slp_reg;
            ssmc_pkg::ADDR_THR: rdata_next = {16'h0, thr_reg};
            ssmc_pkg::ADDR_LDUR: rdata_next = ldur_reg;
            ssmc_pkg::ADDR_STAT: rdata_next = {24'h0, rxd_reg, txd_reg, wake_reg, pdl_reg == ssmc_pkg::LVL_NONE,
                                               1'b0, state_reg};
            ssmc_pkg::ADDR_IRQ: begin
               rdata_next = {29'h0, ist_reg};
               ist_next = '0;
            end
            ssmc_pkg::ADDR_MASK: rdata_next = {29'h0, mask_reg};
            default: rresp_next = ssmc_pkg::RESP_SLVERR;
         endcase
      end
      // A fresh event outranks the clearing read in the same cycle.
      ist_next = ist_next | ev;
      irq_next = |(ist_next & mask_next);
   end
   assign replay_go = ctrl_reg.replay;

   // Detector outcome for the selected method.
   assign lvl_hit = lcnt_reg >= ldur_reg;
   assign sync_hit = freq_dev_mode && (|sync_match);
   always_comb begin
      unique case (ctrl_reg.detector_select)
         ssmc_pkg::DET_LEVEL: hit = lvl_hit;
         ssmc_pkg::DET_SYNC: hit = sync_hit;
         ssmc_pkg::DET_SPECTRAL: hit = spectral_hit;
         ssmc_pkg::DET_LEVEL_SYNC: hit = lvl_hit || sync_hit;
         ssmc_pkg::DET_LEVEL_SPECTRAL: hit = lvl_hit || spectral_hit;
         default: hit = 1'b0;
      endcase
   end
   assign lvl_ok = ctrl_reg.power_down_level >= ssmc_pkg::LVL_CLOCK_SYNTH_DOWN &&
                   ctrl_reg.power_down_level <= ssmc_pkg::LVL_PROCESSOR;
   assign t_done = us_reg == 32'h0;

   // Sleep and monitor sequencer with a microsecond timer.
   always_comb begin
      state_next = state_reg;
      us_next = us_reg;
      pre_next = pre_reg;
      lcnt_next = 32'h0;
      wake_next = wake_reg;
      pdl_next = pdl_reg;
      txd_next = txd_reg;
      rxd_next = rxd_reg;
      ev = '0;
      if (!t_done) begin
         pre_next = (pre_reg == ssmc_pkg::PRE_LAST) ? '0 : pre_reg + 1'b1;
         us_next = (pre_reg == ssmc_pkg::PRE_LAST) ? us_reg - 32'h1 : us_reg;
      end
      // Channel level 2: enable edges switch regulators and synth.
      if (ctrl_reg.chan_level2) begin
         if (tx_q_reg && !tx_enable) txd_next = 1'b1;
         if (!tx_q_reg && tx_enable) txd_next = 1'b0;
         if (rx_q_reg && !rx_enable) rxd_next = 1'b1;
         if (!rx_q_reg && rx_enable) rxd_next = 1'b0;
      end else begin
         txd_next = 1'b0;
         rxd_next = 1'b0;
      end
      unique case (state_reg)
         ssmc_pkg::ST_IDLE: begin
            if (monitor_enable_pin && lvl_ok) begin
               state_next = ssmc_pkg::ST_MON_DELAY;
               us_next = init_reg;
               pre_next = '0;
            end else if (sleep_trigger_pin && !trig_q_reg) begin
               // Enables must be low and both paths primed.
               if (paths_primed && !tx_enable && !rx_enable && lvl_ok) begin
                  state_next = ssmc_pkg::ST_SYS_SLEEP;
                  pdl_next = ctrl_reg.power_down_level;
               end else begin
                  ev[ssmc_pkg::IRQ_REFUSED] = 1'b1;
               end
            end
         end
         ssmc_pkg::ST_SYS_SLEEP: begin
            if (!sleep_trigger_pin) begin
               state_next = ssmc_pkg::ST_IDLE;
               pdl_next = ssmc_pkg::LVL_NONE;
               ev[ssmc_pkg::IRQ_WOKE] = 1'b1;
            end
         end
         ssmc_pkg::ST_MON_DELAY: begin
            if (t_done) begin
               state_next = ctrl_reg.detect_before_sleep ? ssmc_pkg::ST_MON_DETECT : ssmc_pkg::ST_MON_SLEEP;
               us_next = ctrl_reg.detect_before_sleep ? det_reg : slp_reg;
               pdl_next = ctrl_reg.detect_before_sleep ? ssmc_pkg::LVL_NONE : ctrl_reg.power_down_level;
            end
         end
         ssmc_pkg::ST_MON_DETECT: begin
            lcnt_next = (rx_level > thr_reg && !lvl_hit) ? lcnt_reg + 32'h1 : (lvl_hit ? lcnt_reg : 32'h0);
            if (hit) begin
               state_next = ssmc_pkg::ST_MON_WAKE;
               wake_next = 1'b1;
               ev[ssmc_pkg::IRQ_DETECT] = 1'b1;
            end else if (t_done) begin
               state_next = ssmc_pkg::ST_MON_SLEEP;
               us_next = slp_reg;
               pre_next = '0;
               pdl_next = ctrl_reg.power_down_level;
            end
         end
         ssmc_pkg::ST_MON_SLEEP: begin
            if (t_done) begin
               state_next = ssmc_pkg::ST_MON_DETECT;
               us_next = det_reg;
               pre_next = '0;
               pdl_next = ssmc_pkg::LVL_NONE;
            end
         end
         ssmc_pkg::ST_MON_WAKE: ;
         default: state_next = ssmc_pkg::ST_IDLE;
      endcase
      // Dropping monitor enable ends every monitor phase.
      if (state_reg != ssmc_pkg::ST_IDLE && state_reg != ssmc_pkg::ST_SYS_SLEEP && !monitor_enable_pin) begin
         state_next = ssmc_pkg::ST_IDLE;
         wake_next = 1'b0;
         pdl_next = ssmc_pkg::LVL_NONE;
      end
   end

   // Circular sample buffer; only detect phases write, so sleep gaps never overwrite history.
   assign buf_wr = state_reg == ssmc_pkg::ST_MON_DETECT && rx_sample_valid;
   always_comb begin
      wp_next = wp_reg;
      fill_next = fill_reg;
      rp_next = rp_reg;
      rcnt_next = rcnt_reg;
      rs_next = rs_reg;
      rv_next = 1'b0;
      if (state_reg == ssmc_pkg::ST_IDLE && state_next == ssmc_pkg::ST_MON_DELAY) begin
         fill_next = '0;
      end else if (buf_wr) begin
         wp_next = wp_reg + 1'b1;
         fill_next = (fill_reg == (AW+1)'(DEPTH)) ? fill_reg : fill_reg + 1'b1;
      end
      if (rcnt_reg != '0) begin
         rs_next = mem[rp_reg];
         rv_next = 1'b1;
         rp_next = rp_reg + 1'b1;
         rcnt_next = rcnt_reg - 1'b1;
      end else if (replay_go && state_reg == ssmc_pkg::ST_MON_WAKE) begin
         rp_next = wp_reg - fill_reg[AW-1:0];
         rcnt_next = fill_reg;
      end
   end

   // All state registers; a low clock enable freezes everything.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         arready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         bresp_reg <= ssmc_pkg::RESP_OKAY;
         rresp_reg <= ssmc_pkg::RESP_OKAY;
         awaddr_reg <= 8'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         rdata_reg <= 32'h0;
         ctrl_reg <= ssmc_pkg::RST_CTRL;
         init_reg <= ssmc_pkg::RST_TIME;
         det_reg <= ssmc_pkg::RST_TIME;
         slp_reg <= ssmc_pkg::RST_TIME;
         ldur_reg <= ssmc_pkg::RST_TIME;
         thr_reg <= ssmc_pkg::RST_THR;
         ist_reg <= '0;
         mask_reg <= '0;
         irq_reg <= 1'b0;
         state_reg <= ssmc_pkg::ST_IDLE;
         us_reg <= 32'h0;
         pre_reg <= '0;
         lcnt_reg <= 32'h0;
         trig_q_reg <= 1'b0;
         tx_q_reg <= 1'b0;
         rx_q_reg <= 1'b0;
         txd_reg <= 1'b0;
         rxd_reg <= 1'b0;
         wake_reg <= 1'b0;
         pdl_reg <= ssmc_pkg::LVL_NONE;
         wp_reg <= '0;
         fill_reg <= '0;
         rp_reg <= '0;
         rcnt_reg <= '0;
         rs_reg <= '0;
         rv_reg <= 1'b0;
      end else if (clk_en) begin
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
         bvalid_reg <= bvalid_next;
         rvalid_reg <= rvalid_next;
         bresp_reg <= bresp_next;
         rresp_reg <= rresp_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         init_reg <= init_next;
         det_reg <= det_next;
         slp_reg <= slp_next;
         ldur_reg <= ldur_next;
         thr_reg <= thr_next;
         ist_reg <= ist_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
         state_reg <= state_next;
         us_reg <= us_next;
         pre_reg <= pre_next;
         lcnt_reg <= lcnt_next;
         trig_q_reg <= sleep_trigger_pin;
         tx_q_reg <= tx_enable;
         rx_q_reg <= rx_enable;
         txd_reg <= txd_next;
         rxd_reg <= rxd_next;
         wake_reg <= wake_next;
         pdl_reg <= pdl_next;
         wp_reg <= wp_next;
         fill_reg <= fill_next;
         rp_reg <= rp_next;
         rcnt_reg <= rcnt_next;
         rs_reg <= rs_next;
         rv_reg <= rv_next;
         if (buf_wr) begin
            mem[wp_reg] <= rx_sample;
         end
      end
   end

   // Outputs come straight from registers.
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign power_down_level = pdl_reg;
   assign tx_chan_down = txd_reg;
   assign rx_chan_down = rxd_reg;
   assign wake_pin = wake_reg;
   assign replay_sample = rs_reg;
   assign replay_valid = rv_reg;
   assign irq = irq_reg;

   // Checks and coverage, sampled only on enabled cycles.
   default clocking cb @(posedge ref_clk iff clk_en); endclocking
   default disable iff (!rst_n);
   AST_SLEEP_ENTRY: assert property (state_reg == ssmc_pkg::ST_SYS_SLEEP
      |-> pdl_reg >= ssmc_pkg::LVL_CLOCK_SYNTH_DOWN && pdl_reg <= ssmc_pkg::LVL_PROCESSOR)
      else $error("Whole chip sleep with bad level.");
   AST_WAKE_ON_FALL: assert property (state_reg == ssmc_pkg::ST_SYS_SLEEP && !sleep_trigger_pin
      |=> state_reg == ssmc_pkg::ST_IDLE && pdl_reg == ssmc_pkg::LVL_NONE)
      else $error("Trigger fall did not wake the chip.");
   AST_SLEEP_GATED: assert property ($rose(state_reg == ssmc_pkg::ST_SYS_SLEEP)
      |-> $past(paths_primed) && !$past(tx_enable) && !$past(rx_enable))
      else $error("Sleep entered without primed idle paths.");
   AST_CHAN_DOWN: assert property (ctrl_reg.chan_level2 && $fell(tx_enable) |=> tx_chan_down)
      else $error("Transmit channel not powered down.");
   AST_MON_ENTRY: assert property (state_reg == ssmc_pkg::ST_IDLE && monitor_enable_pin && lvl_ok
      |=> state_reg == ssmc_pkg::ST_MON_DELAY)
      else $error("Monitor enable ignored.");
   AST_MON_EXIT: assert property (state_reg != ssmc_pkg::ST_IDLE && state_reg != ssmc_pkg::ST_SYS_SLEEP
      && !monitor_enable_pin |=> state_reg == ssmc_pkg::ST_IDLE && !wake_pin)
      else $error("Monitor mode not left.");
   AST_WAKE_ON_HIT: assert property (state_reg == ssmc_pkg::ST_MON_DETECT && hit && monitor_enable_pin
      |=> wake_pin)
      else $error("Detection did not raise wake.");
   AST_SYNC_HIT: assert property (state_reg == ssmc_pkg::ST_MON_DETECT && ctrl_reg.detector_select == 3'h1
      && freq_dev_mode && sync_match != '0 && monitor_enable_pin |=> state_reg == ssmc_pkg::ST_MON_WAKE)
      else $error("Sync match missed.");
   AST_WAKE_HOLD: assert property (wake_pin && monitor_enable_pin |=> wake_pin)
      else $error("Wake dropped while monitor enabled.");
   AST_REPLAY: assert property (replay_valid |-> $past(rcnt_reg) != '0)
      else $error("Replay without stored samples.");
   COV_SLEEP: cover property (state_reg == ssmc_pkg::ST_SYS_SLEEP ##1 state_reg == ssmc_pkg::ST_IDLE);
   COV_CYCLE: cover property (state_reg == ssmc_pkg::ST_MON_SLEEP ##1 state_reg == ssmc_pkg::ST_MON_DETECT);
   COV_WAKE: cover property ($rose(wake_pin));
   COV_REPLAY: cover property (replay_valid ##1 replay_valid);
endmodule

/* shared/ssmc_pkg.sv */
// Constants, types and register map of the system sleep and monitor controller.
package ssmc_pkg;
   // Clock figures; the microsecond prescale is derived from them.
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US = 1000;
   localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
   localparam int PRE_W = $clog2(CYC_PER_US);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
   localparam int SYNC_N = 14;
   localparam int IRQ_N = 3;
   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INIT = 8'h04;
   localparam logic [7:0] ADDR_DET = 8'h08;
   localparam logic [7:0] ADDR_SLP = 8'h0c;
   localparam logic [7:0] ADDR_THR = 8'h10;
   localparam logic [7:0] ADDR_LDUR = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ = 8'h1c;
   localparam logic [7:0] ADDR_MASK = 8'h20;
   // Interrupt bit positions.
   localparam int IRQ_DETECT = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_WOKE = 2;
   // Power-down levels.
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [2:0] LVL_CLOCK_SYNTH_DOWN = 3'h3;
   localparam logic [2:0] LVL_REGULATOR = 3'h4;
   localparam logic [2:0] LVL_PROCESSOR = 3'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RST_TIME = 32'h0000_000a;
   localparam logic [15:0] RST_THR = 16'h0100;
   typedef enum logic [2:0] {
      DET_LEVEL = 3'h0,
      DET_SYNC = 3'h1,
      DET_SPECTRAL = 3'h2,
      DET_LEVEL_SYNC = 3'h3,
      DET_LEVEL_SPECTRAL = 3'h4
   } ssmc_det_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SYS_SLEEP = 3'h1,
      ST_MON_DELAY = 3'h3,
      ST_MON_DETECT = 3'h2,
      ST_MON_SLEEP = 3'h6,
      ST_MON_WAKE = 3'h7
   } ssmc_state_e;
   // Control register layout.
   typedef struct packed {
      logic [22:0] rsvd;
      logic replay;
      logic chan_level2;
      logic [2:0] detector_select;
      logic detect_before_sleep;
      logic [2:0] power_down_level;
   } ssmc_ctrl_s;
   localparam ssmc_ctrl_s RST_CTRL = '{rsvd: 23'h0, replay: 1'b0, chan_level2: 1'b0,
      detector_select: 3'h0, detect_before_sleep: 1'b1, power_down_level: 3'h3};
endpackage

/* test/ssmc_bbp_model.sv */
// Baseband processor model that drives the sleep trigger and monitor enable pins.
`timescale 1ns/1ns
module ssmc_bbp_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic want_sleep,
   input wire logic want_monitor,
   input wire logic tx_enable,
   input wire logic rx_enable,
   output logic sleep_trigger_pin,
   output logic monitor_enable_pin
);
   // The trigger waits for quiet enables, and the two modes never overlap.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_trigger_pin <= 1'b0;
         monitor_enable_pin <= 1'b0;
      end else begin
         if (!want_sleep || want_monitor) sleep_trigger_pin <= 1'b0;
         else if (!tx_enable && !rx_enable) sleep_trigger_pin <= 1'b1;
         monitor_enable_pin <= want_monitor && !sleep_trigger_pin;
      end
   end
endmodule

/* test/test_system_sleep_monitor_control.sv */
// Self-checking bench for the sleep and monitor controller.
`timescale 1ns/1ns
module test_system_sleep_monitor_control;
   logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, tx_enable = 1'b0, rx_enable = 1'b0;
   logic paths_primed = 1'b1, freq_dev_mode = 1'b0, spectral_hit = 1'b0, rx_sample_valid = 1'b0;
   logic want_sleep = 1'b0, want_monitor = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [13:0] sync_match = 14'h0;
   logic [15:0] rx_level = 16'h0, rx_sample = 16'h0, replay_sample, last_wr, last_rep;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_chan_down;
   logic rx_chan_down, wake_pin, replay_valid, irq, sleep_trigger_pin, monitor_enable_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] power_down_level;
   logic [4:0] evt;
   logic [33:0] exp_q[$];
   int errors = 0, n_compared = 0;
   ssmc_top uut (.*);
   ssmc_bbp_model bbp (.*);
   assign evt = {s_axi_arready, replay_valid, wake_pin, s_axi_rvalid, s_axi_bvalid};
   always #5 ref_clk = ~ref_clk;
   // Fresh samples every cycle give the detect-phase buffer something to replay.
   always @(posedge ref_clk) begin
      rx_sample <= 16'($urandom);
      rx_sample_valid <= 1'b1;
   end
   // The newest sample taken before wake-up must be the last one that the replay delivers.
   always @(posedge ref_clk) begin
      if (!wake_pin) last_wr <= rx_sample;
      if (replay_valid) last_rep <= replay_sample;
   end
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d, compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Bounded wait on one event bit; running out ends the run as a mismatch.
   task automatic wait_for(input int sel);
      int i;
      for (i = 0; i < 2000 && evt[sel] !== 1'b1; i++) @(posedge ref_clk);
      if (i == 2000) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Each channel drops its valid after the edge that took it; the response edge ends the write.
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, 34'h0);
      if (i == 50) begin
         errors++;
         tally_and_finish();
      end
   endtask
   // The expectation is queued here and retired by the read watcher.
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge ref_clk);
      wait_for(4);
      s_axi_arvalid <= 1'b0;
      wait_for(1);
      s_axi_rready <= 1'b0;
   endtask
   // Each accepted read result is compared with the oldest expectation.
   always @(posedge ref_clk) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end
   // Main sequence: reset values, whole-chip sleep, refusal, channel sleep, monitor runs.
   initial begin
      void'($urandom(32'h1f215e73));
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(ssmc_pkg::ADDR_CTRL, 34'h0_0000_000b);
      rd(ssmc_pkg::ADDR_DET, 34'h0_0000_000a);
      rd(ssmc_pkg::ADDR_THR, 34'h0_0000_0100);
      rd(8'h40, 34'h2_0000_0000);
      wr(ssmc_pkg::ADDR_MASK, 32'h7);
      for (int l = 3; l <= 5; l++) begin
         wr(ssmc_pkg::ADDR_CTRL, 32'h8 + 32'(l));
         want_sleep <= 1'b1;
         repeat (4) @(posedge ref_clk);
         chk(power_down_level, 34'(l));
         want_sleep <= 1'b0;
         repeat (4) @(posedge ref_clk);
         chk(power_down_level, 34'h0);
      end
      chk(irq, 34'h1);
      rd(ssmc_pkg::ADDR_IRQ, 34'h0_0000_0004);
      paths_primed <= 1'b0;
      want_sleep <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(power_down_level, 34'h0);
      want_sleep <= 1'b0;
      paths_primed <= 1'b1;
      rd(ssmc_pkg::ADDR_IRQ, 34'h0_0000_0002);
      chk(irq, 34'h0);
      wr(ssmc_pkg::ADDR_CTRL, 32'h8b);
      for (int k = 0; k < 3; k++) begin
         tx_enable <= k != 1;
         rx_enable <= k != 1;
         repeat (4) @(posedge ref_clk);
         chk({tx_chan_down, rx_chan_down}, (k == 1) ? 34'h3 : 34'h0);
      end
      {tx_enable, rx_enable} <= 2'h0;
      wr(ssmc_pkg::ADDR_INIT, 32'h0);
      wr(ssmc_pkg::ADDR_DET, 32'h2);
      wr(ssmc_pkg::ADDR_SLP, 32'h1);
      wr(ssmc_pkg::ADDR_LDUR, 32'h3);
      for (int d = 0; d < 5; d++) begin
         wr(ssmc_pkg::ADDR_CTRL, 32'(d * 16 + 12));
         want_monitor <= 1'b1;
         repeat (32'($urandom % 400)) @(posedge ref_clk);
         chk(wake_pin, 34'h0);
         if (d == 1) freq_dev_mode <= 1'b1;
         if (d == 1) sync_match <= 14'(1 << ($urandom % 14));
         else if (d == 2 || d == 4) spectral_hit <= 1'b1;
         else rx_level <= 16'h0200;
         wait_for(2);
         {freq_dev_mode, spectral_hit, sync_match, rx_level} <= 32'h0;
         repeat (8) @(posedge ref_clk);
         chk(wake_pin, 34'h1);
         if (d == 0) begin
            wr(ssmc_pkg::ADDR_CTRL, 32'h10c);
            wait_for(3);
            repeat (70) @(posedge ref_clk);
            chk(last_rep, last_wr);
         end
         rd(ssmc_pkg::ADDR_IRQ, 34'h0_0000_0001);
         want_monitor <= 1'b0;
         repeat (4) @(posedge ref_clk);
         chk(wake_pin, 34'h0);
      end
      tally_and_finish();
   end
endmodule
